// ==== rtl/sbpm_map.svh ====
// sector buffer pointer manager: offsets, field positions, reset values
// assumes inclusion by the package and the main module only
//
// Functional notes
// - transfer counter is 12-bit down counter, max 4095
// - host bytes limited to programmed transfer count
// - count and host pointer load together
// - disk pointer is low byte plus seven bits
// - armed disk pointer loads on request flag
// - unarmed request flag stalls disk transfers
// - RAM port gated by enable, follows direction
// - control address read returns live status
// - type bit picks XT or AT when master
// - type bit survives every reset
// - read config weakly pulls address pins down
// - counter reset clears counter, self clears
// - host arm latch reloads at zero count
// - host direction bit sets host FIFO direction
// - disk direction bit sets disk FIFO direction
// - burst needs burst enable and host DMA
// - disk arm latch, write zero ignored
// - disk arm clears after pointer load
// - arm in RAM mode resets disk FIFO
// - host arm at zero count reloads at once
// - host pointer is low byte plus seven bits
// - request flag marks disk transfer start
`ifndef SBPM_MAP_SVH
`define SBPM_MAP_SVH

// ------------------------------------------------------------
// register offsets on the microcontroller bus
// ------------------------------------------------------------
`define SBPM_OFS_HOST_PTR_LO   8'h30
`define SBPM_OFS_HOST_PTR_HI   8'h31
`define SBPM_OFS_COUNT_LO      8'h32
`define SBPM_OFS_COUNT_HI      8'h33
`define SBPM_OFS_DISK_PTR_LO   8'h34
`define SBPM_OFS_DISK_PTR_HI   8'h35
`define SBPM_OFS_RAM_PORT      8'h36
`define SBPM_OFS_BUF_CTRL      8'h37

// ------------------------------------------------------------
// buffer control / status field positions
// ------------------------------------------------------------
`define SBPM_BIT_TYPE          7
`define SBPM_BIT_READ_CONFIG_MODE         6
`define SBPM_BIT_RXC           5
`define SBPM_BIT_HOST_ARM      4
`define SBPM_BIT_HOST_DIR      3
`define SBPM_BIT_DISK_DIR      2
`define SBPM_BIT_BURST         1
`define SBPM_BIT_DISK_ARM      0

// ------------------------------------------------------------
// widths and reset values
// ------------------------------------------------------------
`define SBPM_ADDR_W            15
`define SBPM_COUNT_W           12
`define SBPM_HI_PTR_W          7
`define SBPM_HI_COUNT_W        4
`define SBPM_RST_BYTE          8'h00
`define SBPM_RST_COUNT         12'h000

`endif

// ==== rtl/sbpm_pkg.sv ====
// sector buffer pointer manager: shared types
// assumes sbpm_map.svh sits beside it
`include "sbpm_map.svh"

package sbpm_pkg;

  // ----------------------------------------------------------
  // microcontroller bus request, one cycle per strobe
  // ----------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;   // decoded register offset
    logic [7:0] wdata;  // write byte
    logic       wr;     // write strobe
    logic       rd;     // read strobe
  } sbpm_mc_req_t;

  // ----------------------------------------------------------
  // request toward the disk-side FIFO
  // ----------------------------------------------------------
  typedef struct packed {
    logic       clear;  // reset FIFO pointers
    logic       wr;     // push one byte
    logic       rd;     // pop one byte
    logic [7:0] wdata;  // byte to push
  } sbpm_fifo_req_t;

  // ----------------------------------------------------------
  // buffer control / status byte, msb first
  // ----------------------------------------------------------
  typedef struct packed {
    logic host_interface_type;
    logic read_config_mode;
    logic reset_transfer_counter;
    logic host_pointer_arm;
    logic host_direction;
    logic disk_direction;
    logic burst_enable;
    logic disk_pointer_arm;
  } sbpm_ctrl_t;

endpackage : sbpm_pkg

// ==== rtl/sbpm_addr_counter.sv ====
// sector buffer pointer manager: loadable buffer address counter
// assumes load and step come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module sbpm_addr_counter #(
  parameter int W = 15  // address width
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         load,
  input  wire logic [W-1:0] base,
  input  wire logic         step,
  output logic      [W-1:0] addr
);

  // ----------------------------------------------------------
  // load wins over step so a reload never loses its base
  // ----------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      addr <= '0;
    else if (load)
      addr <= base;
    else if (step)
      addr <= addr + W'(1);  // one per byte
  end

endmodule : sbpm_addr_counter

`default_nettype wire

// ==== rtl/sbpm_top.sv ====
// sector buffer pointer manager: pointers, counter, arm latches
// assumes bus strobes, FIFO and byte events share clk
`timescale 1ns/1ps
`default_nettype none
`include "sbpm_map.svh"

module sbpm_top
  import sbpm_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire sbpm_mc_req_t   mc_req,
  output logic [7:0]          mc_rdata,
  input  wire logic           host_slave_select,
  input  wire logic           host_dma_select,
  input  wire logic           ram_access_enable,
  input  wire logic           host_byte_done,
  input  wire logic           disk_byte_done,
  input  wire logic           disk_request_flag,
  input  wire logic [7:0]     disk_fifo_rdata,
  output var sbpm_fifo_req_t  disk_fifo_req,
  output logic                host_fifo_clear,
  output logic [14:0]         host_addr,
  output logic [14:0]         disk_addr,
  output logic [11:0]         transfer_count,
  output logic                host_xfer_enable,
  output logic                buf_addr_oe,
  output logic                buf_addr_pulldown,
  output logic                host_at_mode,
  output logic                host_xt_mode,
  output logic                burst_dma_enable,
  output logic                host_fifo_dir,
  output logic                disk_fifo_dir,
  output logic                disk_stall,
  output logic                host_ptr_loaded,
  output logic                disk_ptr_loaded
);

  // ----------------------------------------------------------
  // programmed registers
  // ----------------------------------------------------------
  logic [7:0]  host_ptr_lo;   // host pointer low byte
  logic [6:0]  host_ptr_hi;   // host pointer upper seven bits
  logic [7:0]  count_lo;      // transfer count low byte
  logic [3:0]  count_hi;      // transfer count upper bits
  logic [7:0]  disk_ptr_lo;   // disk pointer low byte
  logic [6:0]  disk_ptr_hi;   // disk pointer upper seven bits
  logic        type_bit;      // interface type, never reset
  logic        read_config_mode;        // address pins released
  logic        reset_transfer_counter;  // one-cycle counter clear
  logic        host_pointer_arm;        // host reload queued
  logic        host_direction;          // host FIFO direction
  logic        disk_direction;          // disk FIFO direction
  logic        burst_enable;            // burst request bit
  logic        disk_pointer_arm;        // disk reload queued
  sbpm_ctrl_t  ctrl;          // live control and latch state

  // ----------------------------------------------------------
  // decode and event terms
  // ----------------------------------------------------------
  logic [14:0] host_base;     // host pointer as one word
  logic [14:0] disk_base;     // disk pointer as one word
  logic        ctl_wr;        // write to buffer control
  logic        host_load;     // copy pointer and count now
  logic        count_zero;    // transfer counter empty
  logic        flag_d;        // request flag one cycle back
  logic        flag_rise;     // request flag just rose
  logic        disk_arm_set;  // software sets disk arm
  logic        mac_arm;       // arm while in RAM access mode
  logic        disk_load;     // copy disk pointer now
  logic        ram_wr_ok;     // accepted RAM port write
  logic        ram_rd_ok;     // accepted RAM port read

  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = mc_req.wr && (mc_req.addr == ofs);
  endfunction : wr_at

  assign host_base  = {host_ptr_hi, host_ptr_lo};
  assign disk_base  = {disk_ptr_hi, disk_ptr_lo};
  assign ctl_wr     = wr_at(`SBPM_OFS_BUF_CTRL);
  assign count_zero = (transfer_count == `SBPM_RST_COUNT);
  assign flag_rise  = disk_request_flag && !flag_d;

  // reload waits for an empty counter; a counter reset in flight
  // goes first so the fresh count is not wiped the next cycle
  assign host_load  = ctrl.host_pointer_arm && count_zero
                      && !ctrl.reset_transfer_counter;

  assign disk_arm_set = ctl_wr && mc_req.wdata[`SBPM_BIT_DISK_ARM];
  assign mac_arm      = disk_arm_set && ram_access_enable;

  // in RAM access mode the pointer is taken at once so the next
  // microcontroller byte lands at the new address
  assign disk_load = mac_arm
                     || (ctrl.disk_pointer_arm
                         && (flag_rise || disk_stall));

  // RAM port only moves data the way the disk direction allows
  assign ram_wr_ok = wr_at(`SBPM_OFS_RAM_PORT) && ram_access_enable
                     && !ctrl.disk_direction;
  assign ram_rd_ok = mc_req.rd && ram_access_enable
                     && (mc_req.addr == `SBPM_OFS_RAM_PORT)
                     && ctrl.disk_direction;

  // ----------------------------------------------------------
  // pointer and count registers
  // ----------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      host_ptr_lo <= `SBPM_RST_BYTE;
      host_ptr_hi <= '0;
      count_lo    <= `SBPM_RST_BYTE;
      count_hi    <= '0;
      disk_ptr_lo <= `SBPM_RST_BYTE;
      disk_ptr_hi <= '0;
    end
    else
    begin
      if (wr_at(`SBPM_OFS_HOST_PTR_LO))
        host_ptr_lo <= mc_req.wdata;
      if (wr_at(`SBPM_OFS_HOST_PTR_HI))
        host_ptr_hi <= mc_req.wdata[`SBPM_HI_PTR_W-1:0];
      if (wr_at(`SBPM_OFS_COUNT_LO))
        count_lo <= mc_req.wdata;
      if (wr_at(`SBPM_OFS_COUNT_HI))
        count_hi <= mc_req.wdata[`SBPM_HI_COUNT_W-1:0];
      if (wr_at(`SBPM_OFS_DISK_PTR_LO))
        disk_ptr_lo <= mc_req.wdata;
      if (wr_at(`SBPM_OFS_DISK_PTR_HI))
        disk_ptr_hi <= mc_req.wdata[`SBPM_HI_PTR_W-1:0];
    end
  end

  // ----------------------------------------------------------
  // interface type: kept through every reset, so it is
  // unknown until software first writes the control byte
  // ----------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (ctl_wr)
      type_bit <= mc_req.wdata[`SBPM_BIT_TYPE];
  end

  // ----------------------------------------------------------
  // plain control bits
  // ----------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      read_config_mode <= 1'b0;
      host_direction   <= 1'b0;
      disk_direction   <= 1'b0;
      burst_enable     <= 1'b0;
    end
    else if (ctl_wr)
    begin
      read_config_mode <= mc_req.wdata[`SBPM_BIT_READ_CONFIG_MODE];
      host_direction   <= mc_req.wdata[`SBPM_BIT_HOST_DIR];
      disk_direction   <= mc_req.wdata[`SBPM_BIT_DISK_DIR];
      burst_enable     <= mc_req.wdata[`SBPM_BIT_BURST];
    end
  end

  // status byte gathers the type bit and every control bit; one
  // driver for the whole word keeps each field single-sourced
  assign ctrl = {type_bit, read_config_mode, reset_transfer_counter,
                 host_pointer_arm, host_direction, disk_direction,
                 burst_enable, disk_pointer_arm};

  // ----------------------------------------------------------
  // counter reset: one cycle of clearing, then it drops
  // ----------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      reset_transfer_counter <= 1'b0;
    else if (ctl_wr && mc_req.wdata[`SBPM_BIT_RXC])
      reset_transfer_counter <= 1'b1;
    else
      reset_transfer_counter <= 1'b0;
  end

  // ----------------------------------------------------------
  // host arm latch: a write of one sets, zero is ignored;
  // a new set wins over the clear of a load in the same cycle
  // ----------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      host_pointer_arm <= 1'b0;
    else if (ctl_wr && mc_req.wdata[`SBPM_BIT_HOST_ARM])
      host_pointer_arm <= 1'b1;
    else if (host_load)
      host_pointer_arm <= 1'b0;
  end

  // ----------------------------------------------------------
  // disk arm latch: set outside RAM mode, cleared by the load
  // ----------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      disk_pointer_arm <= 1'b0;
    else if (disk_arm_set && !ram_access_enable)
      disk_pointer_arm <= 1'b1;
    else if (disk_load)
      disk_pointer_arm <= 1'b0;
  end

  // ----------------------------------------------------------
  // request edge and stall: an unarmed request holds the disk
  // controller until software arms the pointer
  // ----------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      flag_d <= 1'b0;
    else
      flag_d <= disk_request_flag;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      disk_stall <= 1'b0;
    else if (flag_rise && !ctrl.disk_pointer_arm && !mac_arm)
      disk_stall <= 1'b1;
    else if (disk_load)
      disk_stall <= 1'b0;
  end

  // ----------------------------------------------------------
  // transfer counter: clear, reload, or count one host byte;
  // bytes offered at zero are not counted and not enabled
  // ----------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      transfer_count <= `SBPM_RST_COUNT;
    else if (ctrl.reset_transfer_counter)
      transfer_count <= `SBPM_RST_COUNT;
    else if (host_load)
      transfer_count <= {count_hi, count_lo};
    else if (host_byte_done && !count_zero)
      transfer_count <= transfer_count
                        - `SBPM_COUNT_W'(1);
  end

  assign host_xfer_enable = !count_zero;
  assign host_fifo_clear  = ctrl.reset_transfer_counter;

  // ----------------------------------------------------------
  // buffer address counters
  // ----------------------------------------------------------
  sbpm_addr_counter #(
    .W       (`SBPM_ADDR_W)
  ) u_host_ctr (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (host_load),  // same cycle as the count
    .base    (host_base),
    .step    (host_byte_done && host_xfer_enable),
    .addr    (host_addr)
  );

  sbpm_addr_counter #(
    .W       (`SBPM_ADDR_W)
  ) u_disk_ctr (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (disk_load),
    .base    (disk_base),
    .step    (disk_byte_done),
    .addr    (disk_addr)
  );

  // ----------------------------------------------------------
  // load pulses for the interrupt logic outside
  // ----------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      host_ptr_loaded <= 1'b0;
      disk_ptr_loaded <= 1'b0;
    end
    else
    begin
      host_ptr_loaded <= host_load;
      disk_ptr_loaded <= disk_load;
    end
  end

  // ----------------------------------------------------------
  // disk FIFO requests from the RAM access port
  // ----------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      disk_fifo_req <= '0;
    else
    begin
      disk_fifo_req.clear <= mac_arm;
      disk_fifo_req.wr    <= ram_wr_ok;
      disk_fifo_req.rd    <= ram_rd_ok;
      if (ram_wr_ok)
        disk_fifo_req.wdata <= mc_req.wdata;
    end
  end

  // ----------------------------------------------------------
  // read data: one cycle after the strobe; unmapped reads zero
  // ----------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      mc_rdata <= `SBPM_RST_BYTE;
    else if (mc_req.rd)
    begin
      case (mc_req.addr)
        `SBPM_OFS_HOST_PTR_LO: mc_rdata <= host_ptr_lo;
        `SBPM_OFS_HOST_PTR_HI: mc_rdata <= {1'b0, host_ptr_hi};
        `SBPM_OFS_COUNT_LO:    mc_rdata <= count_lo;
        `SBPM_OFS_COUNT_HI:    mc_rdata <= {4'h0, count_hi};
        `SBPM_OFS_DISK_PTR_LO: mc_rdata <= disk_ptr_lo;
        `SBPM_OFS_DISK_PTR_HI: mc_rdata <= {1'b0, disk_ptr_hi};
        `SBPM_OFS_RAM_PORT:
          mc_rdata <= ram_rd_ok ? disk_fifo_rdata : `SBPM_RST_BYTE;
        `SBPM_OFS_BUF_CTRL:    mc_rdata <= ctrl;
        default:               mc_rdata <= `SBPM_RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------
  // mode outputs
  // ----------------------------------------------------------
  // type bit only matters with the host as master
  assign host_at_mode  = !host_slave_select && type_bit;
  assign host_xt_mode  = !host_slave_select && !type_bit;
  assign burst_dma_enable = ctrl.burst_enable
                            && host_dma_select;
  assign host_fifo_dir = ctrl.host_direction;
  assign disk_fifo_dir = ctrl.disk_direction;
  // pins stop driving and the pad pulldowns take over
  assign buf_addr_oe       = !ctrl.read_config_mode;
  assign buf_addr_pulldown = ctrl.read_config_mode;

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_rxc_write;
    ctl_wr && mc_req.wdata[`SBPM_BIT_RXC];
  endsequence

  sequence s_rxc_done;
    ctrl.reset_transfer_counter ##1
      (!ctrl.reset_transfer_counter && count_zero);
  endsequence

  a_rxc_self_clear: assert property (
    s_rxc_write |=> s_rxc_done)
    else $error("counter reset did not clear and drop");

  a_host_load_pair: assert property (
    host_load |=> (transfer_count == {$past(count_hi), $past(count_lo)})
                  && (host_addr == $past(host_base)) && host_ptr_loaded)
    else $error("count and host pointer not loaded together");

  a_count_hold_zero: assert property (
    count_zero && !ctrl.host_pointer_arm |=> count_zero)
    else $error("counter left zero without a reload");

  a_count_step: assert property (
    host_byte_done && !count_zero && !host_load
      && !ctrl.reset_transfer_counter
    |=> transfer_count == $past(transfer_count) - 12'h001)
    else $error("counter did not step down by one");

  a_host_arm_now: assert property (
    ctrl.host_pointer_arm && count_zero && !ctrl.reset_transfer_counter
    |=> host_ptr_loaded)
    else $error("armed reload at zero count not immediate");

  a_disk_arm_load: assert property (
    ctrl.disk_pointer_arm && flag_rise && !disk_arm_set
    |=> (disk_addr == $past(disk_base)) && !ctrl.disk_pointer_arm)
    else $error("armed disk pointer not loaded on request");

  a_disk_stall_hold: assert property (
    flag_rise && !ctrl.disk_pointer_arm && !mac_arm
    |=> disk_stall ##1 (disk_stall || disk_ptr_loaded))
    else $error("unarmed request did not stall");

  a_ram_gate: assert property (
    mc_req.wr && mc_req.addr == `SBPM_OFS_RAM_PORT && !ram_access_enable
    |=> !disk_fifo_req.wr)
    else $error("RAM port write passed while disabled");

  a_status_read: assert property (
    mc_req.rd && mc_req.addr == `SBPM_OFS_BUF_CTRL
    |=> mc_rdata == $past(ctrl))
    else $error("status read does not match control state");

  a_mac_fifo_clear: assert property (
    mac_arm |=> disk_fifo_req.clear && disk_addr == $past(disk_base))
    else $error("RAM mode arm did not reset disk FIFO");

endmodule : sbpm_top

`default_nettype wire

// ==== verification/sbpm_far_model.sv ====
// far side: disk controller flag and byte strobes, host strobes, FIFO head
// assumes the bench raises the go inputs just after a rising clk edge
`timescale 1ns/1ps
`default_nettype none
module sbpm_far_model
  import sbpm_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire logic           disk_go,
  input  wire logic           disk_run,
  input  wire logic           host_go,
  input  wire logic           disk_stall,
  input  wire sbpm_fifo_req_t disk_fifo_req,
  output logic                disk_request_flag,
  output logic                disk_byte_done,
  output logic                host_byte_done,
  output logic [7:0]          disk_fifo_rdata
);
  // ----------------------------------------------------------
  // strobes every other cycle; head byte moves on each pop
  // ----------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      disk_request_flag <= 1'b0;
      disk_byte_done    <= 1'b0;
      host_byte_done    <= 1'b0;
      disk_fifo_rdata   <= 8'h3C;
    end
    else
    begin
      disk_request_flag <= disk_go;
      // a stalled controller moves no bytes
      disk_byte_done <= disk_run && !disk_stall && !disk_byte_done;
      host_byte_done <= host_go && !host_byte_done;
      if (disk_fifo_req.rd)
        disk_fifo_rdata <= disk_fifo_rdata + 8'h01;
    end
  end
endmodule : sbpm_far_model
`default_nettype wire

// ==== verification/tb.sv ====
// bench: registers, host reload, disk arm/stall and RAM port scenarios
// assumes the far-side model plays the disk and host ends
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sbpm_pkg::*;
  logic clk = 0, reset_n = 0, host_slave_select = 0, host_dma_select = 0;
  logic ram_access_enable = 0, disk_go = 0, disk_run = 0, host_go = 0;
  logic host_byte_done, disk_byte_done, disk_request_flag, host_fifo_clear;
  logic [7:0] mc_rdata, disk_fifo_rdata;
  sbpm_mc_req_t mc_req = '0;
  sbpm_fifo_req_t disk_fifo_req;
  logic [14:0] host_addr, disk_addr;
  logic [11:0] transfer_count;
  logic host_xfer_enable, buf_addr_oe, buf_addr_pulldown, host_at_mode;
  logic host_xt_mode, burst_dma_enable, host_fifo_dir, disk_fifo_dir;
  logic disk_stall, host_ptr_loaded, disk_ptr_loaded;
  int errors = 0, num_checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  sbpm_top dut (.clk, .reset_n, .mc_req, .mc_rdata, .host_slave_select,
    .host_dma_select, .ram_access_enable, .host_byte_done, .disk_byte_done,
    .disk_request_flag, .disk_fifo_rdata, .disk_fifo_req, .host_fifo_clear,
    .host_addr, .disk_addr, .transfer_count, .host_xfer_enable,
    .buf_addr_oe, .buf_addr_pulldown, .host_at_mode, .host_xt_mode,
    .burst_dma_enable, .host_fifo_dir, .disk_fifo_dir, .disk_stall,
    .host_ptr_loaded, .disk_ptr_loaded);
  sbpm_far_model far (.clk, .reset_n, .disk_go, .disk_run, .host_go,
    .disk_stall, .disk_fifo_req, .disk_request_flag, .disk_byte_done,
    .host_byte_done, .disk_fifo_rdata);
  task automatic tick; @(posedge clk); #1; endtask : tick
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one bus cycle; read data is settled when this returns
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    tick;
    mc_req = '{a, d, w, !w};
    tick;
    mc_req = '0;
  endtask : bus
  task automatic rst; reset_n = 0; repeat (10) tick; reset_n = 1; endtask : rst
  task automatic t_regs;
    bus(1, 8'h37, 8'h80);
    bus(1, 8'h33, 8'hFF);
    bus(0, 8'h33, 0);
    chk("count_high", mc_rdata, 8'h0F);
    bus(1, 8'h35, 8'hFF);
    bus(0, 8'h35, 0);
    chk("disk_ptr_high", mc_rdata, 8'h7F);
    bus(0, 8'h20, 0);
    chk("unmapped", mc_rdata, 8'h00);
    chk("at_mode", {host_at_mode, host_xt_mode}, 2'b10);
    host_slave_select = 1;
    #1 chk("slave", {host_at_mode, host_xt_mode}, 2'b00);
    host_slave_select = 0;
    bus(1, 8'h37, 8'h4A);
    chk("modes", {host_xt_mode, buf_addr_oe, buf_addr_pulldown, host_fifo_dir,
      burst_dma_enable}, 5'b10110);
    host_dma_select = 1;
    #1 chk("burst", burst_dma_enable, 1);
    bus(0, 8'h37, 0);
    chk("status", mc_rdata, 8'h4A);
    bus(1, 8'h37, 8'hC0);
    rst;
    chk("after_reset", {host_at_mode, buf_addr_oe}, 2'b11);
    $display("test regs done");
  endtask : t_regs
  task automatic t_host;
    bus(1, 8'h30, 8'h10);
    bus(1, 8'h31, 8'h01);
    bus(1, 8'h32, 8'h03);
    bus(1, 8'h33, 8'h00);
    bus(1, 8'h37, 8'h10);
    for (int i = 0; i < 20 && host_ptr_loaded !== 1'b1; i++) tick;
    chk("reload", {transfer_count, host_addr}, {12'h003, 15'h0110});
    bus(1, 8'h32, 8'h05);
    bus(1, 8'h37, 8'h10);
    bus(0, 8'h37, 0);
    chk("queued", mc_rdata, 8'h10);
    host_go = 1;
    for (int i = 0; i < 40 && host_ptr_loaded !== 1'b1; i++) tick;
    host_go = 0;
    repeat (3) tick;
    chk("count_sum", transfer_count + (host_addr - 15'h0110), 5);
    chk("xfer_en", host_xfer_enable, 1);
    bus(1, 8'h37, 8'h20);
    chk("fifo_clear", host_fifo_clear, 1);
    tick;
    bus(0, 8'h37, 0);
    chk("rxc_done", {mc_rdata, transfer_count}, 0);
    host_go = 1;
    repeat (6) tick;
    host_go = 0;
    chk("zero_drop", {host_xfer_enable, transfer_count}, 0);
    $display("test host done");
  endtask : t_host
  task automatic t_disk;
    bus(1, 8'h34, 8'h22);
    bus(1, 8'h35, 8'h83);
    bus(1, 8'h37, 8'h01);
    bus(1, 8'h37, 8'h00);
    bus(0, 8'h37, 0);
    chk("arm_kept", mc_rdata[0], 1);
    disk_go = 1;
    for (int i = 0; i < 20 && disk_ptr_loaded !== 1'b1; i++) tick;
    chk("disk_load", {disk_addr, disk_stall}, {15'h0322, 1'b0});
    bus(0, 8'h37, 0);
    chk("arm_clear", mc_rdata[0], 0);
    disk_run = 1;
    repeat (4) tick;
    disk_run = 0;
    tick;
    chk("disk_step", disk_addr, 15'h0324);
    disk_go = 0;
    tick;
    disk_go = 1;
    for (int i = 0; i < 20 && disk_stall !== 1'b1; i++) tick;
    chk("stall", disk_stall, 1);
    bus(1, 8'h37, 8'h01);
    for (int i = 0; i < 20 && disk_ptr_loaded !== 1'b1; i++) tick;
    chk("resume", {disk_addr, disk_stall}, {15'h0322, 1'b0});
    disk_go = 0;
    $display("test disk done");
  endtask : t_disk
  task automatic t_ram;
    ram_access_enable = 1;
    bus(1, 8'h34, 8'h40);
    bus(1, 8'h37, 8'h00);
    bus(1, 8'h37, 8'h01);
    chk("ram_arm", {disk_fifo_req.clear, disk_addr}, {1'b1, 15'h0340});
    bus(1, 8'h36, 8'h5A);
    chk("ram_wr", {disk_fifo_req.wr, disk_fifo_req.wdata}, 9'h15A);
    bus(1, 8'h37, 8'h04);
    bus(0, 8'h36, 0);
    chk("ram_rd", {disk_fifo_req.rd, mc_rdata, disk_fifo_dir}, 10'h279);
    ram_access_enable = 0;
    bus(0, 8'h36, 0);
    chk("ram_off", mc_rdata, 0);
    $display("test ram done");
  endtask : t_ram
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  initial
  begin
    rst;
    t_regs;
    t_host;
    t_disk;
    t_ram;
    stop_test;
  end
  // hang guard, far above the hundred or so cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      stop_test;
    end
  end
endmodule : tb
`default_nettype wire
